//--- bcq_pkg.sv
// Shared constants and types for the queue-push and trigger-wait op decoder
`default_nettype none
package bcq_pkg;
   localparam int DATA_W = 16;
   localparam int OP_W   = 5;
   localparam int SYNC_STAGES = 3;

   localparam logic [OP_W-1:0] OP_PUSH_BLOCK_STATUS = 5'h11;
   localparam logic [OP_W-1:0] OP_PUSH_IMMEDIATE    = 5'h12;
   localparam logic [OP_W-1:0] OP_PUSH_INDIRECT     = 5'h13;
   localparam logic [OP_W-1:0] OP_WAIT_TRIGGER      = 5'h14;
   localparam logic [OP_W-1:0] OP_PUSH_TIME_HIGH    = 5'h19;
   localparam logic [OP_W-1:0] OP_PUSH_TIME_BOTH    = 5'h1A;

   localparam logic [15:0] ADDR_TIME_TAG_CONFIG   = 16'h0039;
   localparam logic [15:0] ADDR_BC_TIME_COUNT_LOW  = 16'h0043;
   localparam logic [15:0] ADDR_BC_TIME_COUNT_HIGH = 16'h0044;

   localparam int WIDE_TIME_BIT = 3;

   localparam logic [15:0] RESET_TIME_TAG_CONFIG = 16'h0000;
   localparam logic [15:0] RESET_TIME_COUNT      = 16'h0000;
   localparam logic [15:0] LOW_CLEAR_VALUE       = 16'h0000;

   typedef struct packed {
      logic [OP_W-1:0]   code;
      logic              cond;
      logic [DATA_W-1:0] param;
   } bcq_op_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [15:0]       addr;
      logic [DATA_W-1:0] wdata;
   } bcq_reg_req_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PUSH,
      ST_MEM,
      ST_TRIG,
      ST_HALT
   } bcq_state_t;
endpackage
`default_nettype wire

//--- bcq_trig_sync.sv
// Trigger pin synchroniser with debounced rising-edge pulse
`default_nettype none
module bcq_trig_sync
   import bcq_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic reset_n_i,
   // Asynchronous pin and edge out
   input  wire logic pin_i,
   output logic      rise_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [SYNC_STAGES-1:0] sync_reg;
   logic                   stable_reg;
   logic                   agree;

   // Stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
   assign agree = (sync_reg[1] == sync_reg[2]);

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync_reg   <= '0;
         stable_reg <= 1'b0;
         rise_o     <= 1'b0;
      end else begin
         sync_reg   <= {sync_reg[SYNC_STAGES-2:0], pin_i};
         if (agree) begin
            stable_reg <= sync_reg[2];
         end
         rise_o     <= agree & sync_reg[2] & ~stable_reg;
      end
   end
endmodule
`default_nettype wire

//--- bcq_push_trigger.sv
// Bus controller queue-push and trigger-wait op code executor
// Behaviour
// - True 0x19 pushes high time-tag word
// - False condition: no action, fetch next
// - High/both push need wide bit, else trap
// - Config bit 3 selects wide time base
// - 0x1A captures both words, pushes high then low
// - True 0x11 pushes last block status word
// - True 0x12 pushes its parameter immediately
// - True 0x13 pushes word read at parameter
// - True 0x14 waits for trigger rising edge
// - High load without prior low clears low
`default_nettype none
module bcq_push_trigger
   import bcq_pkg::*;
(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              reset_n_i,
   // Op code from the sequencer
   input  wire logic              op_valid_i,
   input  wire bcq_op_t           op_i,
   output logic                   op_ready_o,
   output logic                   op_done_o,
   // Halt and trap
   input  wire logic              restart_i,
   output logic                   halt_o,
   output logic                   trap_o,
   // General purpose queue
   output logic                   q_push_o,
   output logic [DATA_W-1:0]      q_data_o,
   input  wire logic              q_ready_i,
   // Indirect RAM read
   output logic                   mem_rd_o,
   output logic [15:0]            mem_addr_o,
   input  wire logic              mem_rvalid_i,
   input  wire logic [DATA_W-1:0] mem_rdata_i,
   // Message side and time base
   input  wire logic [DATA_W-1:0] block_status_i,
   input  wire logic              time_tick_i,
   output logic                   controller_wide_time_base_o,
   // Register access
   input  wire bcq_reg_req_t      reg_i,
   output logic [DATA_W-1:0]      reg_rdata_o,
   // External trigger pin
   input  wire logic              controller_trigger_input_i
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////
   bcq_state_t        state_reg, state_next;
   logic              low_pending_reg, low_pending_next;
   logic [DATA_W-1:0] low_cap_reg, low_cap_next;
   logic              push_next, done_next, trap_next, rd_next;
   logic [DATA_W-1:0] qdata_next;
   logic [15:0]       maddr_next;
   logic [DATA_W-1:0] config_reg, time_low_reg, time_high_reg;
   logic              low_loaded_reg;
   logic              trig_rise;

   bcq_trig_sync u_trig (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .pin_i     (controller_trigger_input_i),
      .rise_o    (trig_rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_cfg  = reg_i.wr && (reg_i.addr == ADDR_TIME_TAG_CONFIG);
   wire wr_low  = reg_i.wr && (reg_i.addr == ADDR_BC_TIME_COUNT_LOW);
   wire wr_high = reg_i.wr && (reg_i.addr == ADDR_BC_TIME_COUNT_HIGH);
   wire wide    = config_reg[WIDE_TIME_BIT];
   wire [DATA_W-1:0] rd_mux =
      (reg_i.addr == ADDR_TIME_TAG_CONFIG)    ? config_reg    :
      (reg_i.addr == ADDR_BC_TIME_COUNT_LOW)  ? time_low_reg  :
      (reg_i.addr == ADDR_BC_TIME_COUNT_HIGH) ? time_high_reg : '0;
   wire [31:0] count_inc = {time_high_reg, time_low_reg} + 32'h0000_0001;
   wire        accept    = op_valid_i && (state_reg == ST_IDLE);
   wire        push_hs   = q_push_o && q_ready_i;

   ////////////////////////////////////////////////////////////////////////////
   // Time base registers; a tick in the same cycle as a load loses
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         config_reg     <= RESET_TIME_TAG_CONFIG;
         time_low_reg   <= RESET_TIME_COUNT;
         time_high_reg  <= RESET_TIME_COUNT;
         low_loaded_reg <= 1'b0;
         reg_rdata_o    <= '0;
      end else begin
         if (wr_cfg) begin
            config_reg <= reg_i.wdata;
         end
         if (wr_high) begin
            time_high_reg <= reg_i.wdata;
            if (!low_loaded_reg) begin
               time_low_reg <= LOW_CLEAR_VALUE;
            end
         end else if (wr_low) begin
            time_low_reg <= reg_i.wdata;
         end else if (time_tick_i) begin
            time_low_reg <= count_inc[15:0];
            if (wide) begin
               time_high_reg <= count_inc[31:16];
            end
         end
         // Only a low load directly before keeps the low word
         if (reg_i.wr || accept) begin
            low_loaded_reg <= wr_low;
         end
         if (reg_i.rd) begin
            reg_rdata_o <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Op sequencing
   always_comb begin
      state_next       = state_reg;
      low_pending_next = low_pending_reg;
      low_cap_next     = low_cap_reg;
      push_next        = q_push_o & ~q_ready_i;
      qdata_next       = q_data_o;
      done_next        = 1'b0;
      trap_next        = 1'b0;
      rd_next          = 1'b0;
      maddr_next       = mem_addr_o;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               if (!op_i.cond) begin
                  done_next = 1'b1;
               end else if (op_i.code == OP_PUSH_TIME_HIGH ||
                            op_i.code == OP_PUSH_TIME_BOTH) begin
                  if (!wide) begin
                     trap_next  = 1'b1;
                     state_next = ST_HALT;
                  end else begin
                     push_next        = 1'b1;
                     qdata_next       = time_high_reg;
                     low_cap_next     = time_low_reg;
                     low_pending_next = (op_i.code == OP_PUSH_TIME_BOTH);
                     state_next       = ST_PUSH;
                  end
               end else if (op_i.code == OP_PUSH_BLOCK_STATUS) begin
                  push_next  = 1'b1;
                  qdata_next = block_status_i;
                  state_next = ST_PUSH;
               end else if (op_i.code == OP_PUSH_IMMEDIATE) begin
                  push_next  = 1'b1;
                  qdata_next = op_i.param;
                  state_next = ST_PUSH;
               end else if (op_i.code == OP_PUSH_INDIRECT) begin
                  rd_next    = 1'b1;
                  maddr_next = op_i.param;
                  state_next = ST_MEM;
               end else if (op_i.code == OP_WAIT_TRIGGER) begin
                  state_next = ST_TRIG;
               end else begin
                  done_next = 1'b1;
               end
            end
         end
         ST_PUSH: begin
            if (push_hs) begin
               if (low_pending_reg) begin
                  push_next        = 1'b1;
                  qdata_next       = low_cap_reg;
                  low_pending_next = 1'b0;
               end else begin
                  done_next  = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_MEM: begin
            if (mem_rvalid_i) begin
               push_next  = 1'b1;
               qdata_next = mem_rdata_i;
               state_next = ST_PUSH;
            end
         end
         ST_TRIG: begin
            // Edges seen before the wait began are not remembered
            if (trig_rise) begin
               done_next  = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_HALT: begin
            if (restart_i) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg       <= ST_IDLE;
         low_pending_reg <= 1'b0;
         low_cap_reg     <= '0;
         q_push_o        <= 1'b0;
         q_data_o        <= '0;
         op_done_o       <= 1'b0;
         trap_o          <= 1'b0;
         mem_rd_o        <= 1'b0;
         mem_addr_o      <= '0;
         op_ready_o      <= 1'b1;
         halt_o          <= 1'b0;
         controller_wide_time_base_o <= 1'b0;
      end else begin
         state_reg       <= state_next;
         low_pending_reg <= low_pending_next;
         low_cap_reg     <= low_cap_next;
         q_push_o        <= push_next;
         q_data_o        <= qdata_next;
         op_done_o       <= done_next;
         trap_o          <= trap_next;
         mem_rd_o        <= rd_next;
         mem_addr_o      <= maddr_next;
         op_ready_o      <= (state_next == ST_IDLE);
         halt_o          <= (state_next == ST_HALT);
         controller_wide_time_base_o <= wide;
      end
   end
endmodule
`default_nettype wire

//--- bcq_push_trigger_monitor.sv
// Port assertions for the push and trigger executor
`default_nettype none
module bcq_push_trigger_monitor
   import bcq_pkg::*;
(
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              reset_n_i,
   // Op port
   input  wire logic              op_valid_i,
   input  wire bcq_op_t           op_i,
   input  wire logic              op_ready_o,
   input  wire logic              op_done_o,
   // Halt and trap
   input  wire logic              restart_i,
   input  wire logic              halt_o,
   input  wire logic              trap_o,
   // Queue and indirect read
   input  wire logic              q_push_o,
   input  wire logic [DATA_W-1:0] q_data_o,
   input  wire logic              q_ready_i,
   input  wire logic              mem_rd_o,
   input  wire logic [15:0]       mem_addr_o,
   // Message side, registers and trigger
   input  wire logic [DATA_W-1:0] block_status_i,
   input  wire logic              controller_wide_time_base_o,
   input  wire bcq_reg_req_t      reg_i,
   input  wire logic              controller_trigger_input_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   wire  acc      = op_valid_i && op_ready_o;
   wire  wait_acc = acc && op_i.cond && (op_i.code == OP_WAIT_TRIGGER);
   wire  pin      = controller_trigger_input_i;
   wire  time_op  = (op_i.code == OP_PUSH_TIME_HIGH) || (op_i.code == OP_PUSH_TIME_BOTH);
   wire  cfg_wr   = reg_i.wr && (reg_i.addr == ADDR_TIME_TAG_CONFIG);
   logic wait_reg;

   // Tracks an accepted trigger wait until its done pulse
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= wait_acc || (wait_reg && !op_done_o);
      end
   end

   sequence s_take(c);
      acc && op_i.cond && (op_i.code == c);
   endsequence
   // Pin held low from accept on: the wait must not end by itself
   sequence s_quiet_wait;
      wait_acc && !pin ##1 !pin [*6];
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   chk_false_cond: assert property (
      acc && !op_i.cond |=> op_done_o && !q_push_o && !mem_rd_o)
      else $error("false condition acted");
   chk_imm_word: assert property (
      s_take(OP_PUSH_IMMEDIATE) |=> q_push_o && (q_data_o == $past(op_i.param)))
      else $error("immediate word wrong");
   chk_status_word: assert property (
      s_take(OP_PUSH_BLOCK_STATUS) |=> q_push_o && (q_data_o == $past(block_status_i)))
      else $error("status word wrong");
   chk_indirect_read: assert property (
      s_take(OP_PUSH_INDIRECT) |=> mem_rd_o && (mem_addr_o == $past(op_i.param)))
      else $error("indirect read wrong");
   chk_illegal_trap: assert property (
      acc && op_i.cond && time_op && !controller_wide_time_base_o
      |=> trap_o && halt_o && !op_done_o && !q_push_o)
      else $error("missing trap");
   chk_halt_hold: assert property (
      halt_o && !restart_i |=> halt_o)
      else $error("halt dropped");
   // The copy lags the register by one flop, so it shows two edges after the write
   chk_wide_copy: assert property (
      cfg_wr |-> ##2 (controller_wide_time_base_o == $past(reg_i.wdata[WIDE_TIME_BIT], 2)))
      else $error("wide bit not copied");
   chk_push_hold: assert property (
      q_push_o && !q_ready_i |=> q_push_o && $stable(q_data_o))
      else $error("push word not held");
   chk_trig_stall: assert property (
      s_quiet_wait |-> !op_done_o)
      else $error("wait ended without edge");
   chk_trig_release: assert property (
      wait_reg && $rose(pin) |-> ##[2:7] op_done_o)
      else $error("edge did not release wait");
   chk_ready_done: assert property (
      op_done_o |-> op_ready_o)
      else $error("not ready at done");
endmodule
bind bcq_push_trigger bcq_push_trigger_monitor u_mon (
   .clock_i, .reset_n_i, .op_valid_i, .op_i, .op_ready_o, .op_done_o, .restart_i, .halt_o,
   .trap_o, .q_push_o, .q_data_o, .q_ready_i, .mem_rd_o, .mem_addr_o, .block_status_i,
   .controller_wide_time_base_o, .reg_i, .controller_trigger_input_i
);
`default_nettype wire

//--- bcq_far_model.sv
// Far-side model: queue acceptor and RAM for indirect reads
`default_nettype none
module bcq_far_model
   import bcq_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   input  wire logic        slow_i,
   input  wire logic        rd_i,
   input  wire logic [15:0] addr_i,
   output logic             ready_o,
   output logic             rvalid_o,
   output logic [15:0]      rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  lat;
   logic [15:0] addr_q;
   // Idle read data toggles so a stale word never passes for an answer
   always @(negedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {lat, ready_o, rvalid_o, rdata_o} <= '0;
      end else begin
         ready_o  <= slow_i ? 1'($urandom_range(0, 1)) : 1'b1;
         rvalid_o <= lat == 3'h1;
         rdata_o  <= lat == 3'h1 ? {addr_q[7:0], addr_q[15:8]} : ~rdata_o;
         if (rd_i) lat <= slow_i ? 3'h6 : 3'h1;
         else if (lat != 3'h0) lat <= lat - 3'h1;
         if (rd_i) addr_q <= addr_i;
      end
   end
endmodule
`default_nettype wire

//--- bcq_push_trigger_tb.sv
// Self-checking bench for the push and trigger executor
`default_nettype none
module bcq_push_trigger_tb
   import bcq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 0, reset_n_i = 0, op_valid_i = 0, restart_i = 0, time_tick_i = 0;
   logic controller_trigger_input_i = 0, slow_i = 0, cd;
   bcq_op_t op_i = '0;
   bcq_reg_req_t reg_i = '0;
   logic [15:0] block_status_i = '0, q_data_o, mem_rdata_i, reg_rdata_o, mem_addr_o;
   logic op_ready_o, op_done_o, halt_o, trap_o, q_push_o, q_ready_i, mem_rd_o;
   logic mem_rvalid_i, controller_wide_time_base_o;
   logic [15:0] got[$], hi, lo, p, r;
   logic [4:0] c;
   int err_total = 0, checked = 0, n, traps = 0;
   bcq_push_trigger u_dut (
      .clock_i, .reset_n_i, .op_valid_i, .op_i, .op_ready_o, .op_done_o, .restart_i,
      .halt_o, .trap_o, .q_push_o, .q_data_o, .q_ready_i, .mem_rd_o, .mem_addr_o,
      .mem_rvalid_i, .mem_rdata_i, .block_status_i, .time_tick_i,
      .controller_wide_time_base_o, .reg_i, .reg_rdata_o, .controller_trigger_input_i
   );
   bcq_far_model u_far (.clock_i, .reset_n_i, .slow_i, .rd_i(mem_rd_o), .addr_i(mem_addr_o),
      .ready_o(q_ready_i), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
   initial begin
      forever #2.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      if (q_push_o === 1'b1 && q_ready_i === 1'b1) got.push_back(q_data_o);
      if (trap_o === 1'b1) traps++;
   end
   function automatic logic [15:0] swap16(input logic [15:0] a);
      return {a[7:0], a[15:8]};
   endfunction
   task automatic stop_test;
      $display("checks=%0d errors=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic pop_chk(input logic [15:0] e);
      chk(got.size() > 0 ? got.pop_front() : ~e, e);
   endtask
   task automatic reg_acc(input logic w, input logic [15:0] a, input logic [15:0] d);
      reg_i = '{w, !w, a, d};
      @(negedge clock_i);
      reg_i = '0;
      r = reg_rdata_o;
      @(negedge clock_i);
   endtask
   task automatic run_op(input logic [4:0] code, input logic cond, input logic [15:0] prm);
      op_i = '{code, cond, prm};
      op_valid_i = 1'b1;
      @(negedge clock_i);
      op_valid_i = 1'b0;
      n = 1;
      while (op_done_o !== 1'b1 && halt_o !== 1'b1 && n < 200) begin
         @(negedge clock_i);
         n++;
      end
      @(negedge clock_i);
   endtask
   task automatic wait_op(input int d);
      fork
         begin
            repeat (d) @(negedge clock_i);
            controller_trigger_input_i = 1'b1;
            repeat (8) @(negedge clock_i);
            controller_trigger_input_i = 1'b0;
         end
      join_none
      run_op(OP_WAIT_TRIGGER, 1'b1, 16'($urandom));
      chk(n >= d && n < 200, 16'h0001);
   endtask
   initial begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      stop_test;
   end
   initial begin
      void'($urandom(86));
      repeat (10) @(negedge clock_i);
      reset_n_i = 1'b1;
      for (int i = 0; i < 4; i++) begin
         reg_acc(1'b0, 16'h0039 + 16'(i * 5), 16'h0000);
         chk(r, 16'h0000);
      end
      for (int i = 0; i < 2; i++) begin
         run_op(i ? OP_PUSH_TIME_BOTH : OP_PUSH_TIME_HIGH, 1'b1, 16'($urandom));
         chk({15'h0000, halt_o}, 16'h0001);
         chk(16'(traps), 16'(i + 1));
         chk(16'(got.size()), 16'h0000);
         restart_i = 1'b1;
         @(negedge clock_i);
         restart_i = 1'b0;
      end
      reg_acc(1'b1, ADDR_TIME_TAG_CONFIG, 16'h0008);
      chk({15'h0000, controller_wide_time_base_o}, 16'h0001);
      hi = 16'($urandom);
      reg_acc(1'b1, ADDR_BC_TIME_COUNT_LOW, 16'hFFFF);
      reg_acc(1'b1, ADDR_BC_TIME_COUNT_HIGH, hi);
      time_tick_i = 1'b1;
      @(negedge clock_i);
      time_tick_i = 1'b0;
      hi = hi + 16'h0001;
      reg_acc(1'b0, ADDR_BC_TIME_COUNT_HIGH, 16'h0000);
      chk(r, hi);
      lo = 16'($urandom);
      reg_acc(1'b1, ADDR_BC_TIME_COUNT_LOW, lo);
      reg_acc(1'b1, ADDR_BC_TIME_COUNT_HIGH, hi);
      reg_acc(1'b0, ADDR_BC_TIME_COUNT_LOW, 16'h0000);
      chk(r, lo);
      reg_acc(1'b1, ADDR_BC_TIME_COUNT_HIGH, hi);
      reg_acc(1'b0, ADDR_BC_TIME_COUNT_LOW, 16'h0000);
      chk(r, LOW_CLEAR_VALUE);
      reg_acc(1'b1, ADDR_BC_TIME_COUNT_LOW, lo);
      // Long wait first, so the pin is still low for the stall check
      wait_op(10);
      wait_op(6);
      for (int i = 0; i < 60; i++) begin
         c = 5'h11 + 5'($urandom_range(0, 3));
         if ($urandom_range(0, 2) == 0) c = $urandom_range(0, 1) ? 5'h19 : 5'h1A;
         // A code outside this group must finish with no push
         if ($urandom_range(0, 9) == 0) c = 5'h1F;
         cd = (c == OP_WAIT_TRIGGER) ? 1'b0 : 1'($urandom_range(0, 1));
         p = 16'($urandom);
         block_status_i = 16'($urandom);
         slow_i = 1'($urandom_range(0, 1));
         run_op(c, cd, p);
         if (cd && c == OP_PUSH_BLOCK_STATUS) pop_chk(block_status_i);
         if (cd && c == OP_PUSH_IMMEDIATE) pop_chk(p);
         if (cd && c == OP_PUSH_INDIRECT) pop_chk(swap16(p));
         if (cd && (c == OP_PUSH_TIME_HIGH || c == OP_PUSH_TIME_BOTH)) pop_chk(hi);
         if (cd && c == OP_PUSH_TIME_BOTH) pop_chk(lo);
         chk(16'(got.size()), 16'h0000);
      end
      stop_test;
   end
endmodule
`default_nettype wire
